// File: inc/ctfd_regs.svh
// offsets, reset values and configuration-information bytes of the task-file decoder
`ifndef CTFD_REGS_SVH
`define CTFD_REGS_SVH

// ==========================================================
// task-file register offsets (A3..A0)
`define CTFD_OFF_DATA 4'h0
`define CTFD_OFF_ERR_FEAT 4'h1
`define CTFD_OFF_SEC_CNT 4'h2
`define CTFD_OFF_SEC_NUM 4'h3
`define CTFD_OFF_CYL_LO 4'h4
`define CTFD_OFF_CYL_HI 4'h5
`define CTFD_OFF_DRV_HEAD 4'h6
`define CTFD_OFF_STAT_CMD 4'h7
`define CTFD_OFF_DUP_EVEN 4'h8
`define CTFD_OFF_DUP_ODD 4'h9
`define CTFD_OFF_DUP_ERR 4'hD
`define CTFD_OFF_ALT_CTRL 4'hE
`define CTFD_OFF_DRV_ADDR 4'hF

// ==========================================================
// configuration index that selects the memory-mapped decode
`define CTFD_IDX_MEM 6'h00

// ==========================================================
// reset values of host-written registers, and the byte read at undefined locations
`define CTFD_TF_RST 8'h00
`define CTFD_DATA_RST 16'h0000
`define CTFD_UNDEF_RD 8'h00

// ==========================================================
// configuration information: attribute address and byte held there
`define CTFD_CIS_A_IO1_LO 11'h112
`define CTFD_CIS_D_IO1_LO 8'h70
`define CTFD_CIS_A_IO1_HI 11'h114
`define CTFD_CIS_D_IO1_HI 8'h01
`define CTFD_CIS_A_IO1_LEN 11'h116
`define CTFD_CIS_D_IO1_LEN 8'h07
`define CTFD_CIS_A_IO2_LO 11'h118
`define CTFD_CIS_D_IO2_LO 8'h76
`define CTFD_CIS_A_IO2_HI 11'h11A
`define CTFD_CIS_D_IO2_HI 8'h03
`define CTFD_CIS_A_IO2_LEN 11'h11C
`define CTFD_CIS_D_IO2_LEN 8'h01
`define CTFD_CIS_A_IRQ 11'h11E
`define CTFD_CIS_D_IRQ 8'hEE
`define CTFD_CIS_A_MISC 11'h120
`define CTFD_CIS_D_MISC 8'h20
`define CTFD_CIS_A_CFT 11'h122
`define CTFD_CIS_D_CFT 8'h1B
`define CTFD_CIS_A_CFT_LNK 11'h124
`define CTFD_CIS_D_CFT_LNK 8'h06
`define CTFD_CIS_A_INDX 11'h126
`define CTFD_CIS_D_INDX 8'h03
`define CTFD_CIS_A_FS 11'h128
`define CTFD_CIS_D_FS 8'h01
`define CTFD_CIS_A_PWR 11'h12A
`define CTFD_CIS_D_PWR 8'h21
`define CTFD_CIS_A_VNOM 11'h12C
`define CTFD_CIS_D_VNOM 8'hB5
`define CTFD_CIS_A_VEXT 11'h12E
`define CTFD_CIS_D_VEXT 8'h1E
`define CTFD_CIS_A_IAVG 11'h130
`define CTFD_CIS_D_IAVG 8'h4D
`define CTFD_CIS_A_NOLNK 11'h132
`define CTFD_CIS_D_NOLNK 8'h14
`define CTFD_CIS_A_NOLNK_L 11'h134
`define CTFD_CIS_D_NOLNK_L 8'h00
`define CTFD_CIS_A_END 11'h136
`define CTFD_CIS_D_END 8'hFF

`endif

// File: inc/ctfd_pkg.sv
// types shared by the task-file decoder modules
package ctfd_pkg;

  // ==========================================================
  // decoded target of one host access
  typedef enum logic [3:0] {
    TGT_NONE = 4'h0,
    TGT_DATA_WORD = 4'h1,
    TGT_DATA_EVEN = 4'h2,
    TGT_DATA_ODD = 4'h3,
    TGT_ERR_FEAT = 4'h4,
    TGT_SEC_CNT = 4'h5,
    TGT_SEC_NUM = 4'h6,
    TGT_CYL_LO = 4'h7,
    TGT_CYL_HI = 4'h8,
    TGT_DRV_HEAD = 4'h9,
    TGT_STAT_CMD = 4'hA,
    TGT_ALT_CTRL = 4'hB,
    TGT_DRV_ADDR = 4'hC,
    TGT_ATTR = 4'hD
  } ctfd_tgt_t;

  // ==========================================================
  // host access phase, one bit changes from idle to either phase
  typedef enum logic [1:0] {
    ACC_IDLE = 2'h0,
    ACC_READ = 2'h1,
    ACC_WRITE = 2'h2
  } ctfd_acc_t;

endpackage : ctfd_pkg

// File: src/ctfd_cis_rom.sv
// configuration information bytes at attribute addresses 112H to 136H
`timescale 1ns/1ps
`include "ctfd_regs.svh"

module ctfd_cis_rom
(
  input wire logic [10:0] attr_addr,
  output logic [7:0] cis_byte,
  output logic cis_hit
);

  // ==========================================================
  // byte lookup; odd or unlisted addresses give no defined data
  always_comb
  begin
    cis_hit = 1'b1;
    case (attr_addr)
      `CTFD_CIS_A_IO1_LO: cis_byte = `CTFD_CIS_D_IO1_LO;
      `CTFD_CIS_A_IO1_HI: cis_byte = `CTFD_CIS_D_IO1_HI;
      `CTFD_CIS_A_IO1_LEN: cis_byte = `CTFD_CIS_D_IO1_LEN;
      `CTFD_CIS_A_IO2_LO: cis_byte = `CTFD_CIS_D_IO2_LO;
      `CTFD_CIS_A_IO2_HI: cis_byte = `CTFD_CIS_D_IO2_HI;
      `CTFD_CIS_A_IO2_LEN: cis_byte = `CTFD_CIS_D_IO2_LEN;
      `CTFD_CIS_A_IRQ: cis_byte = `CTFD_CIS_D_IRQ;
      `CTFD_CIS_A_MISC: cis_byte = `CTFD_CIS_D_MISC;
      `CTFD_CIS_A_CFT: cis_byte = `CTFD_CIS_D_CFT;
      `CTFD_CIS_A_CFT_LNK: cis_byte = `CTFD_CIS_D_CFT_LNK;
      `CTFD_CIS_A_INDX: cis_byte = `CTFD_CIS_D_INDX;
      `CTFD_CIS_A_FS: cis_byte = `CTFD_CIS_D_FS;
      `CTFD_CIS_A_PWR: cis_byte = `CTFD_CIS_D_PWR;
      `CTFD_CIS_A_VNOM: cis_byte = `CTFD_CIS_D_VNOM;
      `CTFD_CIS_A_VEXT: cis_byte = `CTFD_CIS_D_VEXT;
      `CTFD_CIS_A_IAVG: cis_byte = `CTFD_CIS_D_IAVG;
      `CTFD_CIS_A_NOLNK: cis_byte = `CTFD_CIS_D_NOLNK;
      `CTFD_CIS_A_NOLNK_L: cis_byte = `CTFD_CIS_D_NOLNK_L;
      `CTFD_CIS_A_END: cis_byte = `CTFD_CIS_D_END;
      default:
      begin
        cis_byte = `CTFD_UNDEF_RD;
        cis_hit = 1'b0;
      end
    endcase
  end

endmodule : ctfd_cis_rom

// File: src/ctfd_task_file.sv
// memory-mode task-file decoder with its register file and attribute window
// Behaviour
// - decode choice follows the configuration index the host wrote
// - index 0: decode when register select high, A10 low; A3..A0 is offset
// - offsets 0..6: data, error/feature, count, number, cyl low/high, drive-head
// - offset 7 reads status, writes command; E reads alt status, writes control
// - 8 and 9 duplicate even and odd data bytes; D duplicates error/feature
// - offset F reads drive address; writes there have no effect
// - A10 high ignores A9..A1; A0 picks even or odd data byte
// - attribute 112H/114H hold 70H/01H, first I/O base
// - attribute 116H holds 07H, first I/O length minus one
// - attribute 118H/11AH hold 76H/03H, second I/O base
// - attribute 11CH holds 01H, second I/O length minus one
// - attribute 11EH holds EEH, the interrupt descriptor
// - attribute 120H holds 20H, the miscellaneous features byte
// - attribute 122H holds 1BH entry tuple, then link byte 06H
// - attribute 126H holds 03H, entry number 3
// - attribute 128H holds 01H, supply power info only
// - 132H holds 14H, link 00H; 136H holds FFH end of list
// - data register is 16-bit read/write, word or byte accessible
`timescale 1ns/1ps
`include "ctfd_regs.svh"

module ctfd_task_file
  import ctfd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic reg_sel,
  input wire logic [10:0] addr,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] data_in,
  input wire logic [5:0] cfg_index,
  input wire logic [7:0] core_status,
  input wire logic [7:0] core_error,
  input wire logic [7:0] core_drive_addr,
  input wire logic [15:0] core_data,
  input wire logic core_data_load,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic [15:0] sector_data_port,
  output logic [7:0] option_byte,
  output logic [7:0] sector_count,
  output logic [7:0] sector_index,
  output logic [7:0] track_low,
  output logic [7:0] track_high,
  output logic [7:0] unit_surface,
  output logic [7:0] opcode,
  output logic opcode_strobe,
  output logic [7:0] control_byte,
  output logic data_wr_strobe,
  output logic data_rd_strobe
);

  // ==========================================================
  // address decode
  function automatic ctfd_tgt_t tf_decode(
    input logic rs,
    input logic [10:0] a,
    input logic [5:0] idx
  );
    ctfd_tgt_t t;
    t = TGT_NONE;
    if (!rs)
      t = TGT_ATTR;
    else if (idx != `CTFD_IDX_MEM)
      t = TGT_NONE;
    else if (a[10])
      t = a[0] ? TGT_DATA_ODD : TGT_DATA_EVEN;
    else
    begin
      // A9..A4 take no part in the choice
      case (a[3:0])
        `CTFD_OFF_DATA: t = TGT_DATA_WORD;
        `CTFD_OFF_ERR_FEAT: t = TGT_ERR_FEAT;
        `CTFD_OFF_SEC_CNT: t = TGT_SEC_CNT;
        `CTFD_OFF_SEC_NUM: t = TGT_SEC_NUM;
        `CTFD_OFF_CYL_LO: t = TGT_CYL_LO;
        `CTFD_OFF_CYL_HI: t = TGT_CYL_HI;
        `CTFD_OFF_DRV_HEAD: t = TGT_DRV_HEAD;
        `CTFD_OFF_STAT_CMD: t = TGT_STAT_CMD;
        `CTFD_OFF_DUP_EVEN: t = TGT_DATA_EVEN;
        `CTFD_OFF_DUP_ODD: t = TGT_DATA_ODD;
        `CTFD_OFF_DUP_ERR: t = TGT_ERR_FEAT;
        `CTFD_OFF_ALT_CTRL: t = TGT_ALT_CTRL;
        `CTFD_OFF_DRV_ADDR: t = TGT_DRV_ADDR;
        default: t = TGT_NONE; // offsets A..C
      endcase
    end
    return t;
  endfunction : tf_decode

  // ==========================================================
  // state
  ctfd_acc_t acc_state_reg;
  ctfd_acc_t acc_state_next;
  logic [15:0] data_out_reg;
  logic data_oe_reg;
  logic [15:0] data_word_reg;
  logic [7:0] option_reg;
  logic [7:0] sec_cnt_reg;
  logic [7:0] sec_num_reg;
  logic [7:0] cyl_lo_reg;
  logic [7:0] cyl_hi_reg;
  logic [7:0] drv_head_reg;
  logic [7:0] opcode_reg;
  logic opcode_strobe_reg;
  logic [7:0] control_reg;
  logic data_wr_strobe_reg;
  logic data_rd_strobe_reg;

  // ==========================================================
  // decode and access edges
  wire ctfd_tgt_t tgt;
  wire logic [7:0] cis_byte;
  wire logic cis_hit;
  wire logic rd_active;
  wire logic wr_active;
  wire logic rd_edge;
  wire logic wr_edge;
  wire logic [7:0] wr_byte;

  assign tgt = tf_decode(reg_sel, addr, cfg_index);
  // read wins when the host glitches both strobes low together
  assign rd_active = !oe_n;
  assign wr_active = oe_n && !we_n;
  // one commit per strobe: a write held over many clocks lands once
  assign rd_edge = rd_active && (acc_state_reg != ACC_READ);
  assign wr_edge = wr_active && (acc_state_reg != ACC_WRITE);
  // byte-wide accesses use the low lane
  assign wr_byte = data_in[7:0];

  // attribute bytes come from the configuration table
  ctfd_cis_rom u_cis
  (
    .attr_addr(addr),
    .cis_byte(cis_byte),
    .cis_hit(cis_hit)
  );

  // ==========================================================
  // read data selection
  wire logic [15:0] rd_mux;
  wire logic [7:0] rd_byte;

  assign rd_byte =
    (tgt == TGT_DATA_EVEN) ? data_word_reg[7:0] :
    (tgt == TGT_DATA_ODD) ? data_word_reg[15:8] :
    (tgt == TGT_ERR_FEAT) ? core_error :
    (tgt == TGT_SEC_CNT) ? sec_cnt_reg :
    (tgt == TGT_SEC_NUM) ? sec_num_reg :
    (tgt == TGT_CYL_LO) ? cyl_lo_reg :
    (tgt == TGT_CYL_HI) ? cyl_hi_reg :
    (tgt == TGT_DRV_HEAD) ? drv_head_reg :
    (tgt == TGT_STAT_CMD) ? core_status :
    (tgt == TGT_ALT_CTRL) ? core_status :
    (tgt == TGT_DRV_ADDR) ? core_drive_addr :
    ((tgt == TGT_ATTR) && cis_hit) ? cis_byte :
    `CTFD_UNDEF_RD;
  assign rd_mux = (tgt == TGT_DATA_WORD) ? data_word_reg : {8'h00, rd_byte};

  // ==========================================================
  // access phase tracking
  always_comb
  begin
    case (acc_state_reg)
      ACC_IDLE, ACC_READ, ACC_WRITE:
        acc_state_next = rd_active ? ACC_READ : (wr_active ? ACC_WRITE : ACC_IDLE);
      default: acc_state_next = ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      acc_state_reg <= ACC_IDLE;
    else
      acc_state_reg <= acc_state_next;
  end

  // ==========================================================
  // read port: data stands one clock after the strobe and address
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_out_reg <= `CTFD_DATA_RST;
      data_oe_reg <= 1'b0;
    end
    else
    begin
      data_out_reg <= rd_active ? rd_mux : `CTFD_DATA_RST;
      data_oe_reg <= rd_active;
    end
  end

  // ==========================================================
  // data register; host write beats a core load in the same clock
  wire logic wr_word;
  wire logic wr_even;
  wire logic wr_odd;

  assign wr_word = wr_edge && (tgt == TGT_DATA_WORD);
  assign wr_even = wr_edge && (tgt == TGT_DATA_EVEN);
  assign wr_odd = wr_edge && (tgt == TGT_DATA_ODD);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      data_word_reg <= `CTFD_DATA_RST;
    else if (wr_word)
      data_word_reg <= data_in;
    else if (wr_even)
      data_word_reg[7:0] <= wr_byte;
    else if (wr_odd)
      data_word_reg[15:8] <= wr_byte;
    else if (core_data_load)
      data_word_reg <= core_data;
  end

  // the word is complete after a word write or its odd byte
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_wr_strobe_reg <= 1'b0;
      data_rd_strobe_reg <= 1'b0;
    end
    else
    begin
      data_wr_strobe_reg <= wr_word || wr_odd;
      data_rd_strobe_reg <= rd_edge && ((tgt == TGT_DATA_WORD) || (tgt == TGT_DATA_ODD));
    end
  end

  // ==========================================================
  // byte registers written by the host
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      option_reg <= `CTFD_TF_RST;
      sec_cnt_reg <= `CTFD_TF_RST;
      sec_num_reg <= `CTFD_TF_RST;
      cyl_lo_reg <= `CTFD_TF_RST;
      cyl_hi_reg <= `CTFD_TF_RST;
      drv_head_reg <= `CTFD_TF_RST;
    end
    else if (wr_edge)
    begin
      if (tgt == TGT_ERR_FEAT) option_reg <= wr_byte;
      if (tgt == TGT_SEC_CNT) sec_cnt_reg <= wr_byte;
      if (tgt == TGT_SEC_NUM) sec_num_reg <= wr_byte;
      if (tgt == TGT_CYL_LO) cyl_lo_reg <= wr_byte;
      if (tgt == TGT_CYL_HI) cyl_hi_reg <= wr_byte;
      if (tgt == TGT_DRV_HEAD) drv_head_reg <= wr_byte;
    end
  end

  // command and device control; offset F and A..C fall through
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      opcode_reg <= `CTFD_TF_RST;
      opcode_strobe_reg <= 1'b0;
      control_reg <= `CTFD_TF_RST;
    end
    else
    begin
      opcode_strobe_reg <= wr_edge && (tgt == TGT_STAT_CMD);
      if (wr_edge && (tgt == TGT_STAT_CMD)) opcode_reg <= wr_byte;
      if (wr_edge && (tgt == TGT_ALT_CTRL)) control_reg <= wr_byte;
    end
  end

  // ==========================================================
  // outputs
  assign data_out = data_out_reg;
  assign data_oe = data_oe_reg;
  assign sector_data_port = data_word_reg;
  assign option_byte = option_reg;
  assign sector_count = sec_cnt_reg;
  assign sector_index = sec_num_reg;
  assign track_low = cyl_lo_reg;
  assign track_high = cyl_hi_reg;
  assign unit_surface = drv_head_reg;
  assign opcode = opcode_reg;
  assign opcode_strobe = opcode_strobe_reg;
  assign control_byte = control_reg;
  assign data_wr_strobe = data_wr_strobe_reg;
  assign data_rd_strobe = data_rd_strobe_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_wr(ctfd_tgt_t t);
    wr_edge && (tgt == t);
  endsequence

  sequence s_pulse(logic sig);
    sig ##1 !sig;
  endsequence

  index_gate_a: assert property (
    (wr_edge && reg_sel && (cfg_index != `CTFD_IDX_MEM)) |=>
      $stable(sec_cnt_reg) && !opcode_strobe && !data_wr_strobe)
    else $error("task-file write taken under a non-memory index");

  count_write_a: assert property (
    s_wr(TGT_SEC_CNT) |=> sector_count == $past(data_in[7:0]))
    else $error("sector count not loaded by its write");

  opcode_pulse_a: assert property (
    s_wr(TGT_STAT_CMD) |=> s_pulse(opcode_strobe))
    else $error("command write did not give a one-clock strobe");

  status_read_a: assert property (
    (!oe_n && reg_sel && !addr[10] && (addr[3:0] == `CTFD_OFF_STAT_CMD)
      && (cfg_index == `CTFD_IDX_MEM))
      |=> data_oe && (data_out == {8'h00, $past(core_status)}))
    else $error("status read returned wrong data");

  dup_feature_a: assert property (
    (s_wr(TGT_ERR_FEAT) and (addr[3] == 1'b1)) |=> option_byte == $past(data_in[7:0]))
    else $error("duplicate feature write lost");

  reserved_write_a: assert property (
    s_wr(TGT_DRV_ADDR) |=> $stable(control_byte) && $stable(opcode) && !opcode_strobe)
    else $error("write at drive address location had an effect");

  hole_write_a: assert property (
    (wr_edge && (tgt == TGT_NONE)) |=> $stable(sector_data_port) && $stable(option_byte))
    else $error("write to an unmapped offset had an effect");

  odd_lane_a: assert property (
    s_wr(TGT_DATA_ODD) |=> (sector_data_port[15:8] == $past(data_in[7:0]))
      && $stable(sector_data_port[7:0]) ##0 s_pulse(data_wr_strobe))
    else $error("odd data byte write wrong");

  attr_base_a: assert property (
    (!oe_n && !reg_sel && (addr == `CTFD_CIS_A_IO1_LO)) |=> data_out[7:0] == `CTFD_CIS_D_IO1_LO)
    else $error("first I/O base low byte wrong");

  attr_end_a: assert property (
    (!oe_n && !reg_sel && (addr == `CTFD_CIS_A_END)) |=> data_out == 16'h00FF)
    else $error("end-of-list byte wrong");

  word_pop_a: assert property (
    (rd_edge && (tgt == TGT_DATA_WORD)) |=> s_pulse(data_rd_strobe))
    else $error("data word read did not pulse the pop strobe");

endmodule : ctfd_task_file

// File: sim/ctfd_host_model.sv
// host bus controller model driving the card slot strobes, address and write data
`timescale 1ns/1ps

module ctfd_host_model
(
  input wire logic clk_sys,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  output logic reg_sel,
  output logic [10:0] addr,
  output logic oe_n,
  output logic we_n,
  output logic [15:0] data_in
);
  // extra cycles a strobe is held low, so a slow host can be modelled
  int stretch = 0;

  // ==========================================================
  // idle bus at time zero
  initial
  begin
    reg_sel = 1'b1;
    addr = 11'h000;
    oe_n = 1'b1;
    we_n = 1'b1;
    data_in = 16'hA5C3;
  end

  // ==========================================================
  // one write: strobe and qualifiers held until the taking edge has passed
  task automatic wr(input logic rs, input logic [10:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_sel <= rs;
    addr <= a;
    data_in <= d;
    we_n <= 1'b0;
    repeat (1 + stretch) @(posedge clk_sys);
    we_n <= 1'b1;
    data_in <= ~d; // released lane shows the inverse, never a stale copy
    @(posedge clk_sys); // strobe high for at least one edge between writes
  endtask : wr

  // ==========================================================
  // one read: answer taken 1 ns after an edge that sees the strobe low, strobe then held one more clock
  task automatic rd(input logic rs, input logic [10:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk_sys);
    reg_sel <= rs;
    addr <= a;
    oe_n <= 1'b0;
    repeat (1 + stretch) @(posedge clk_sys);
    #1;
    d = data_out;
    v = data_oe;
    @(posedge clk_sys);
    oe_n <= 1'b1;
  endtask : rd
endmodule : ctfd_host_model

// File: sim/card_task_file_decode_test.sv
// self-checking testbench of the memory-mode task-file decoder
`timescale 1ns/1ps

module card_task_file_decode_test;
  logic clk_sys, arst_n, reg_sel, oe_n, we_n, data_oe, core_data_load;
  logic [10:0] addr;
  logic [15:0] data_in, data_out, sector_data_port, core_data, rdat;
  logic [5:0] cfg_index;
  logic [7:0] core_status, core_error, core_drive_addr, option_byte, sector_count;
  logic [7:0] sector_index, track_low, track_high, unit_surface, opcode, control_byte;
  logic opcode_strobe, data_wr_strobe, data_rd_strobe, rvalid;
  int failures = 0, samples_checked = 0, cycles = 0, n_cmd = 0, n_wr = 0, n_rd = 0;
  logic [7:0] cis [19] = '{8'h70, 8'h01, 8'h07, 8'h76, 8'h03, 8'h01, 8'hEE, 8'h20, 8'h1B,
    8'h06, 8'h03, 8'h01, 8'h21, 8'hB5, 8'h1E, 8'h4D, 8'h14, 8'h00, 8'hFF};

  ctfd_host_model host (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe),
    .reg_sel(reg_sel), .addr(addr), .oe_n(oe_n), .we_n(we_n), .data_in(data_in));

  ctfd_task_file dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_sel(reg_sel), .addr(addr),
    .oe_n(oe_n), .we_n(we_n), .data_in(data_in), .cfg_index(cfg_index),
    .core_status(core_status), .core_error(core_error), .core_drive_addr(core_drive_addr),
    .core_data(core_data), .core_data_load(core_data_load), .data_out(data_out),
    .data_oe(data_oe), .sector_data_port(sector_data_port), .option_byte(option_byte),
    .sector_count(sector_count), .sector_index(sector_index), .track_low(track_low),
    .track_high(track_high), .unit_surface(unit_surface), .opcode(opcode),
    .opcode_strobe(opcode_strobe), .control_byte(control_byte),
    .data_wr_strobe(data_wr_strobe), .data_rd_strobe(data_rd_strobe));

  // ==========================================================
  // clock, strobe pulse counters and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // counting high cycles shows a pulse that stands longer than one clock
  always @(posedge clk_sys)
  begin
    cycles++;
    if (opcode_strobe === 1'b1) n_cmd++;
    if (data_wr_strobe === 1'b1) n_wr++;
    if (data_rd_strobe === 1'b1) n_rd++;
    if (cycles == 5000)
    begin
      failures++;
      summarize();
    end
  end

  // ==========================================================
  // comparison, read-and-compare and verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rchk(input logic rs, input logic [10:0] a, input logic [15:0] exp);
    host.rd(rs, a, rdat, rvalid);
    chk(rdat, exp);
    chk({15'h0000, rvalid}, 16'h0001);
  endtask : rchk

  // pulses are counted one edge late, so let two edges pass first
  task automatic settle();
    repeat (2) @(posedge clk_sys);
  endtask : settle

  // host registers after the byte-register and command tests
  task automatic tf_same();
    chk({option_byte, sector_count}, 16'h775A);
    chk({sector_index, track_low}, 16'h3344);
    chk({track_high, unit_surface}, 16'h5566);
    chk({opcode, control_byte}, 16'hEC06);
  endtask : tf_same

  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ==========================================================
  // main sequence
  initial
  begin
    arst_n = 1'b0;
    cfg_index = 6'h00;
    core_status = 8'h50;
    core_error = 8'h04;
    core_drive_addr = 8'hC1;
    core_data = 16'h0000;
    core_data_load = 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    chk(sector_data_port, 16'h0000);
    // byte registers, with A9..A4 set on the last write
    for (int i = 1; i < 7; i++) host.wr(1'b1, 11'(i), {8'hFF, 8'(8'h11 * i)});
    host.wr(1'b1, 11'h3F2, 16'h005A);
    for (int i = 3; i < 7; i++) rchk(1'b1, 11'(i), {8'h00, 8'(8'h11 * i)});
    rchk(1'b1, 11'h3A2, 16'h005A);
    $display("test byte registers done");
    // a non-zero configuration index decodes no task-file register
    @(posedge clk_sys) cfg_index <= 6'h01;
    host.wr(1'b1, 11'h002, 16'h0099);
    rchk(1'b1, 11'h002, 16'h0000);
    chk({8'h00, sector_count}, 16'h005A);
    @(posedge clk_sys) cfg_index <= 6'h00;
    $display("test index done");
    // slow command write still gives a single pulse
    host.stretch = 2;
    host.wr(1'b1, 11'h007, 16'h00EC);
    host.stretch = 0;
    settle();
    chk(16'(n_cmd), 16'h0001);
    host.wr(1'b1, 11'h00E, 16'h0006);
    host.wr(1'b1, 11'h00D, 16'h0077);
    rchk(1'b1, 11'h007, 16'h0050);
    rchk(1'b1, 11'h00E, 16'h0050);
    rchk(1'b1, 11'h001, 16'h0004);
    rchk(1'b1, 11'h00D, 16'h0004);
    rchk(1'b1, 11'h00F, 16'h00C1);
    host.wr(1'b1, 11'h00F, 16'h003C);
    tf_same();
    for (int i = 10; i < 13; i++)
    begin
      host.wr(1'b1, 11'(i), 16'h00E7);
      rchk(1'b1, 11'(i), 16'h0000);
    end
    tf_same();
    $display("test command and status done");
    // data register by word, by duplicate bytes and through A10
    host.wr(1'b1, 11'h000, 16'hBEEF);
    settle();
    chk(sector_data_port, 16'hBEEF);
    chk(16'(n_wr), 16'h0001);
    rchk(1'b1, 11'h000, 16'hBEEF);
    settle();
    chk(16'(n_rd), 16'h0001);
    host.wr(1'b1, 11'h008, 16'hFF12);
    settle();
    chk(16'(n_wr), 16'h0001);
    host.wr(1'b1, 11'h009, 16'hFF34);
    settle();
    chk(16'(n_wr), 16'h0002);
    chk(sector_data_port, 16'h3412);
    rchk(1'b1, 11'h008, 16'h0012);
    rchk(1'b1, 11'h009, 16'h0034);
    host.wr(1'b1, 11'h7FE, 16'h00AB);
    host.wr(1'b1, 11'h401, 16'h00CD);
    chk(sector_data_port, 16'hCDAB);
    rchk(1'b1, 11'h5FE, 16'h00AB);
    rchk(1'b1, 11'h7FF, 16'h00CD);
    @(posedge clk_sys)
    begin
      core_data <= 16'h1357;
      core_data_load <= 1'b1;
    end
    @(posedge clk_sys) core_data_load <= 1'b0;
    rchk(1'b1, 11'h000, 16'h1357);
    tf_same();
    $display("test data register done");
    // configuration information bytes at even addresses, then odd 113H and 137H read as zero
    for (int i = 0; i < 19; i++)
      rchk(1'b0, 11'h112 + 11'(2 * i), {8'h00, cis[i]});
    rchk(1'b0, 11'h113, 16'h0000);
    rchk(1'b0, 11'h137, 16'h0000);
    $display("test attribute table done");
    summarize();
  end
endmodule : card_task_file_decode_test
